// *** rtl/cache_controller_end.sv ***
/*
  Cache controller end of the global bus: one master that runs memory,
  I/O, send and receive sequences for its user-side commands.
  Assumes the arbiter and memory controller share clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module cache_controller_end import global_bus_pkg::*; #(
  parameter int ID = 0
) (
  input wire logic clk_i, // Clock, one bus cycle
  input wire logic rst_i, // Synchronous reset
  global_bus_if.cache_end bus, // Global bus
  input wire logic cmd_valid_i, // Command offered
  input wire logic [3:0] cmd_op_i, // Command code
  input wire logic [31:0] cmd_addr_i, // Read, send or receive address
  input wire logic [31:0] cmd_waddr_i, // Write address
  input wire logic [127:0] cmd_line_i, // Line or I/O word (low word)
  input wire logic [CREG_W-1:0] cmd_creg_i, // Register number
  input wire logic ext_irq_clr_i, // Clear recorded interrupt
  output logic cmd_ready_o, // Command accepted when valid
  output logic line_valid_o, // Line received
  output logic [127:0] line_o, // Received line
  output logic io_valid_o, // I/O result valid
  output logic [31:0] io_data_o, // I/O result
  output logic send_done_o, // Send matched
  output logic local_interrupt_o, // Local interrupt level
  output logic ext_irq_o // Recorded external interrupt
);
  typedef enum logic [3:0] {H_IDLE, H_REQ, H_START, H_RADDR, H_WADDR,
                            H_WDATA, H_DROP, H_IO, H_IOWAIT, H_SEND,
                            H_SWAIT, H_RECV} cc_st_t;
  typedef struct packed {
    cc_st_t st;
    logic [3:0] op;
    logic [31:0] addr;
    logic [31:0] waddr;
    logic [LINE_WORDS-1:0][WORD_W-1:0] line;
    logic [CREG_W-1:0] creg;
    logic [2:0] idx;
    logic request;
    logic oe;
    logic [BUS_W-1:0] dout;
    logic send;
    logic rd_start;
    logic wr_start;
    logic io_op;
    logic io_rd;
    logic io_wr;
    logic ld;
    logic matched;
    logic rcv;
    logic match_oe;
    logic rd_wait;
    logic [2:0] rcnt;
    logic [LINE_WORDS-1:0][WORD_W-1:0] lout;
    logic lvalid;
    logic io_val;
    logic [31:0] io_data;
    logic [31:0] prev_fmb;
    logic seen_low;
    logic done;
    logic local_irq;
    logic ext_irq;
    logic rdy;
  } cc_state_t;

  cc_state_t s;
  cc_state_t next_s;
  logic granted;

  assign granted = bus.bus_grant_a[ID];

  always_comb begin
    next_s = s;
    next_s.lvalid = 1'b0;
    next_s.io_val = 1'b0;
    next_s.done = 1'b0;
    next_s.rd_start = 1'b0;
    next_s.wr_start = 1'b0;
    next_s.io_op = 1'b0;
    next_s.io_rd = 1'b0;
    next_s.io_wr = 1'b0;
    next_s.ld = 1'b0;
    next_s.prev_fmb = bus.from_memory_bus[31:0];
    case (s.st)
      H_IDLE: begin
        if (cmd_valid_i && s.rdy) begin
          next_s.op = cmd_op_i;
          next_s.addr = cmd_addr_i;
          next_s.waddr = cmd_waddr_i;
          next_s.line = cmd_line_i;
          next_s.creg = cmd_creg_i;
          next_s.idx = 3'h0;
          if (cmd_op_i == OP_RECEIVE) begin
            next_s.st = H_RECV;
            next_s.rcv = 1'b1; // R9
          end else begin
            next_s.st = H_REQ;
            next_s.request = 1'b1; // R4
          end
        end
      end
      H_REQ: begin
        if (granted) begin
          next_s.idx = 3'h0;
          if (s.op == OP_SEND) begin
            next_s.st = H_SEND;
            next_s.send = 1'b1; // R8
            next_s.oe = 1'b1;
            next_s.dout = with_parity(s.addr); // R6
            next_s.idx = 3'h1;
          end else if (s.op <= OP_WRITE) begin
            next_s.st = H_START;
          end else begin
            next_s.st = H_IO;
            next_s.request = 1'b0; // R4
            next_s.io_op = 1'b1;
            next_s.io_rd = s.op == OP_IO_READ; // R17
            next_s.io_wr = s.op == OP_IO_WRITE; // R17
            next_s.ld = s.op == OP_LOAD_REG; // R17
            next_s.oe = 1'b1;
            next_s.dout = with_parity(s.line[0]);
          end
        end
      end
      H_START: begin
        if (bus.mem_ready) begin // R12
          // A flush goes out as a read/write whose read line is dropped,
          // since write_start may only follow read_start.
          next_s.rd_start = 1'b1; // R10 R11
          next_s.st = H_RADDR;
          next_s.rd_wait = s.op != OP_WRITE;
          next_s.rcnt = 3'h0;
        end
      end
      H_RADDR: begin
        next_s.oe = 1'b1;
        next_s.dout = with_parity(s.addr); // R10
        next_s.wr_start = s.op != OP_READ; // R11
        next_s.request = s.op != OP_READ; // R15
        next_s.st = (s.op != OP_READ) ? H_WADDR : H_DROP; // R15
      end
      H_WADDR: begin
        next_s.oe = 1'b1;
        next_s.dout = with_parity(s.waddr); // R11
        next_s.st = H_WDATA;
      end
      H_WDATA: begin
        next_s.dout = with_parity(s.line[s.idx[1:0]]); // R14
        next_s.idx = s.idx + 3'h1;
        if (s.idx == 3'h3) begin
          next_s.request = 1'b0; // R4 R14
          next_s.st = H_DROP;
        end
      end
      H_DROP: begin
        next_s.oe = 1'b0;
        next_s.st = H_IDLE;
      end
      H_IO: begin
        next_s.oe = 1'b0;
        next_s.seen_low = 1'b0;
        next_s.st = H_IOWAIT;
      end
      H_IOWAIT: begin
        if (!bus.io_ready) begin
          next_s.seen_low = 1'b1;
        end else if (s.seen_low) begin
          next_s.io_data = s.prev_fmb; // R20
          next_s.io_val = 1'b1;
          next_s.st = H_IDLE;
        end
      end
      H_SEND: begin
        // Word k is on the bus while idx is k+2; match follows word one.
        if (s.idx == 3'h3) begin
          next_s.matched = !bus.remote_match_n; // R8
        end
        if (s.idx == 3'h5) begin
          next_s.send = 1'b0;
          next_s.oe = 1'b0;
          next_s.done = s.matched;
          next_s.st = s.matched ? H_IDLE : H_SWAIT;
        end else begin
          next_s.dout = with_parity(s.line[s.idx[1:0] - 2'h1]);
          next_s.idx = s.idx + 3'h1;
          next_s.request = s.idx != 3'h4; // R4
        end
      end
      H_SWAIT: begin
        if (!bus.receive_pending_n) begin
          next_s.st = H_REQ; // R9
          next_s.request = 1'b1;
        end
      end
      H_RECV: begin
        if (s.idx == 3'h0) begin
          if (bus.send && bus.data[31:0] == s.addr) begin
            next_s.match_oe = 1'b1; // R8
            next_s.idx = 3'h1;
          end
        end else begin
          next_s.lout[s.idx[1:0] - 2'h1] = bus.data[31:0];
          next_s.idx = s.idx + 3'h1;
          if (s.idx == 3'h4) begin
            next_s.match_oe = 1'b0;
            next_s.rcv = 1'b0;
            next_s.lvalid = 1'b1;
            next_s.st = H_IDLE;
          end
        end
      end
      default: next_s.st = H_IDLE;
    endcase

    if (s.rd_wait && (bus.read_data_ready || s.rcnt != 3'h0)) begin // R13
      next_s.lout[s.rcnt[1:0]] = bus.from_memory_bus[31:0]; // R23
      next_s.rcnt = s.rcnt + 3'h1;
      if (s.rcnt == 3'h3) begin
        next_s.rcnt = 3'h0;
        next_s.rd_wait = 1'b0;
        next_s.lvalid = 1'b1;
      end
    end
    // One outstanding read: a new command waits for the last read line.
    next_s.rdy = next_s.st == H_IDLE && !next_s.rd_wait && !next_s.lvalid;
    next_s.local_irq = !bus.interrupt_n[ID]; // R7
    next_s.ext_irq = (s.ext_irq && !ext_irq_clr_i) || next_s.local_irq; // R7
  end

  always_ff @(posedge clk_i) begin // R21
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Bus outputs are launched at the edge, sampled by others one cycle on.
  assign bus.bus_request_m = MASTERS'({7'h00, s.request}) << ID;
  assign bus.data_m = s.dout;
  assign bus.data_oe_m = s.oe;
  assign bus.send_m = s.send;
  assign bus.read_start = s.rd_start;
  assign bus.write_start = s.wr_start;
  assign bus.io_operation = s.io_op;
  assign bus.io_read_start = s.io_rd;
  assign bus.io_write_start = s.io_wr;
  assign bus.load_controller_register = s.ld;
  assign bus.controller_register_number = s.creg;
  assign bus.receive_oe_m = s.rcv;
  assign bus.match_oe_m = s.match_oe;
  assign cmd_ready_o = s.rdy;
  assign line_valid_o = s.lvalid;
  assign line_o = s.lout;
  assign io_valid_o = s.io_val;
  assign io_data_o = s.io_data;
  assign send_done_o = s.done;
  assign local_interrupt_o = s.local_irq;
  assign ext_irq_o = s.ext_irq;
endmodule
`default_nettype wire

// *** common/global_bus_pkg.sv ***
/*
  Shared constants and helpers of the global bus: widths, register
  numbers, reset values, command codes and byte parity.
  Assumes one clk_i cycle stands for one full four-phase bus cycle.
*/
// What this block does
// R1: One to four 32MB modules, four-word transfers.
// R2: Clean miss read, dirty miss read/write, flush write.
// R3: Write words accepted during the read access.
// R4: Master requests bus, drops request one cycle early.
// R5: At most one grant; only granted master drives.
// R6: Master drives multiplexed address/data with byte parity.
// R7: Low-true interrupt bus; memory uses bit zero.
// R8: Sender strobes send; matching receiver asserts match.
// R9: Receiver asserts pending; stalled senders rebroadcast.
// R10: Read start, then read address next cycle.
// R11: Write start only right after read start.
// R12: Hold start until ready; ready low while busy.
// R13: Data ready marks first read word exactly.
// R14: Read/write: address, four words, then release.
// R15: Read-only: release right after the address.
// R16: I/O operation returns register chosen last time.
// R17: At most one I/O qualifier per operation.
// R18: I/O read, I/O write, register load actions.
// R19: Register number captured on each I/O operation.
// R20: I/O ready one cycle after register drive.
// R21: Launch at cycle start, sample at cycle end.
// R22: Arbiter latches requests, serves in fixed priority.
// R23: Remaining three read words follow back to back.
package global_bus_pkg;

  localparam int WORD_W = 32;
  localparam int PAR_W = 4;
  localparam int BUS_W = WORD_W + PAR_W;
  localparam int LINE_WORDS = 4;
  localparam int MASTERS = 8;
  localparam int CREG_W = 3;
  localparam int NUM_CREGS = 8;
  localparam int LINE_OFS = 4;
  localparam int MAX_MODULES = 4;
  localparam logic [31:0] MODULE_BYTES = 32'h0200_0000;
  localparam logic [CREG_W-1:0] STATUS_REG = 3'h0;
  localparam logic [CREG_W-1:0] IO_DATA_REG = 3'h7;
  localparam int ERR_PARITY = 0;
  localparam int ERR_RANGE = 1;
  localparam int MOD_COUNT_POS = 8;
  localparam logic MEM_READY_RST = 1'b1;
  localparam logic IO_READY_RST = 1'b1;

  localparam logic [3:0] OP_READ = 4'h0;
  localparam logic [3:0] OP_READ_WRITE = 4'h1;
  localparam logic [3:0] OP_WRITE = 4'h2;
  localparam logic [3:0] OP_IO_PEEK = 4'h3;
  localparam logic [3:0] OP_IO_READ = 4'h4;
  localparam logic [3:0] OP_IO_WRITE = 4'h5;
  localparam logic [3:0] OP_LOAD_REG = 4'h6;
  localparam logic [3:0] OP_SEND = 4'h7;
  localparam logic [3:0] OP_RECEIVE = 4'h8;

  // Even parity per byte, parity bits above the data word.
  function automatic logic [BUS_W-1:0] with_parity(input logic [31:0] w);
    return {^w[31:24], ^w[23:16], ^w[15:8], ^w[7:0], w};
  endfunction

  function automatic logic parity_ok(input logic [BUS_W-1:0] b);
    return with_parity(b[31:0]) == b;
  endfunction

endpackage

// *** common/global_bus_if.sv ***
/*
  Global bus wiring between one cache controller and the memory controller.
  Assumes the testbench drives the other_* signals to stand for the other
  seven masters, and resolves tri-state and open-collector lines here.
*/
`timescale 1ns/1ps
`default_nettype none
interface global_bus_if;
  import global_bus_pkg::*;

  logic [MASTERS-1:0] bus_request_m;
  logic [MASTERS-1:0] other_request;
  logic [MASTERS-1:0] bus_request;
  logic [MASTERS-1:0] bus_grant_a;
  logic [BUS_W-1:0] data_m;
  logic data_oe_m;
  logic [BUS_W-1:0] other_data;
  logic other_oe;
  logic [BUS_W-1:0] data;
  logic [BUS_W-1:0] to_memory_bus;
  logic send_m;
  logic other_send;
  logic send;
  logic read_start;
  logic write_start;
  logic io_operation;
  logic io_read_start;
  logic io_write_start;
  logic load_controller_register;
  logic [CREG_W-1:0] controller_register_number;
  logic mem_ready;
  logic read_data_ready;
  logic io_ready;
  logic [BUS_W-1:0] from_memory_bus;
  logic receive_oe_m;
  logic other_receive_oe;
  logic receive_pending_n;
  logic match_oe_m;
  logic other_match_oe;
  logic remote_match_n;
  logic irq_oe_d;
  logic [MASTERS-1:0] other_irq_oe;
  logic [MASTERS-1:0] interrupt_n;

  assign bus_request = bus_request_m | other_request;
  assign data = data_oe_m ? data_m : (other_oe ? other_data : '0);
  assign to_memory_bus = data;
  assign send = send_m | other_send;
  assign receive_pending_n = ~(receive_oe_m | other_receive_oe);
  assign remote_match_n = ~(match_oe_m | other_match_oe);
  assign interrupt_n = ~({{(MASTERS-1){1'b0}}, irq_oe_d} | other_irq_oe);

  modport memory_end (
    input bus_request, to_memory_bus, read_start, write_start,
    input io_operation, io_read_start, io_write_start,
    input load_controller_register, controller_register_number,
    output bus_grant_a, mem_ready, read_data_ready, io_ready,
    output from_memory_bus, irq_oe_d
  );

  modport cache_end (
    output bus_request_m, data_m, data_oe_m, send_m, read_start,
    output write_start, io_operation, io_read_start, io_write_start,
    output load_controller_register, controller_register_number,
    output receive_oe_m, match_oe_m,
    input bus_grant_a, data, send, mem_ready, read_data_ready, io_ready,
    input from_memory_bus, receive_pending_n, remote_match_n, interrupt_n
  );
endinterface
`default_nettype wire

// *** rtl/memory_controller_end.sv ***
/*
  Memory controller end of the global bus with the bus arbiter, plus the
  two-entry buffer on its read-data path.
  Assumes all bus inputs come from logic on clk_i and one master at a time.
*/
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Two-entry buffer
// ----------------------------------------------------------------
module two_entry_buffer #(
  parameter int W = 32,
  parameter int DEPTH = 2
) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Synchronous reset
  input wire logic in_valid_i, // Word offered
  output logic in_ready_o, // Room for a word
  input wire logic [W-1:0] in_data_i, // Word in
  output logic out_valid_o, // Word available
  input wire logic out_ready_i, // Drain side takes it
  output logic [W-1:0] out_data_o // Word out
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } buf_t;
  buf_t s;
  buf_t next_s;
  logic push;
  logic pop;

  assign in_ready_o = s.cnt != (PW+1)'(DEPTH);
  assign out_valid_o = s.cnt != '0;
  assign out_data_o = s.mem[s.rp];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wp] = in_data_i;
      next_s.wp = (s.wp == PW'(DEPTH - 1)) ? '0 : s.wp + PW'(1);
    end
    if (pop) begin
      next_s.rp = (s.rp == PW'(DEPTH - 1)) ? '0 : s.rp + PW'(1);
    end
    next_s.cnt = s.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// ----------------------------------------------------------------
// Memory controller and arbiter
// ----------------------------------------------------------------
module memory_controller_end import global_bus_pkg::*; #(
  parameter int NUM_MODULES = MAX_MODULES,
  parameter int LINES = 8,
  parameter int READ_LAT = 6
) (
  input wire logic clk_i, // Clock, one bus cycle
  input wire logic rst_i, // Synchronous reset
  global_bus_if.memory_end bus, // Global bus
  input wire logic device_irq_i, // I/O device interrupt
  input wire logic io_rd_valid_i, // I/O read data valid
  input wire logic [31:0] io_rd_data_i, // I/O read data
  output logic io_rd_req_o, // I/O read started
  output logic io_wr_valid_o, // I/O write started
  output logic [31:0] io_wr_data_o // I/O write data
);
  localparam int IDX_W = $clog2(LINES);
  localparam int LAT_W = $clog2(READ_LAT + 1);
  localparam logic [31:0] MEM_TOP = 32'(NUM_MODULES) * MODULE_BYTES;

  typedef enum logic [2:0] {S_IDLE, S_RADDR, S_WADDR, S_WDATA, S_BUSY} mc_st_t;
  typedef logic [LINE_WORDS-1:0][WORD_W-1:0] line_t;
  typedef struct packed {
    mc_st_t st;
    logic [LINES-1:0][LINE_WORDS-1:0][WORD_W-1:0] mem;
    line_t rd_buf;
    logic [IDX_W-1:0] wr_idx;
    logic [LAT_W-1:0] wait_cnt;
    logic [1:0] wcnt;
    logic [1:0] pcnt;
    logic [1:0] ocnt;
    logic rd_pend;
    logic mem_rdy;
    logic drdy;
    logic [BUS_W-1:0] fmb;
    logic [NUM_CREGS-1:0][WORD_W-1:0] creg;
    logic [CREG_W-1:0] sel;
    logic io_drive;
    logic io_rdy;
    logic [1:0] err;
    logic irq;
    logic [1:0] irq_sync;
    logic io_rd_req;
    logic io_wr;
    logic [WORD_W-1:0] io_wr_data;
    logic [MASTERS-1:0] latched;
    logic [MASTERS-1:0] grant;
  } mc_state_t;

  mc_state_t s;
  mc_state_t next_s;
  logic push_valid;
  logic push_ready;
  logic pop_valid;
  logic pop_ready;
  logic [WORD_W-1:0] pop_data;
  logic [BUS_W-1:0] tm;
  logic [IDX_W-1:0] tm_idx;
  logic [1:0] err_set;
  logic [1:0] err_clr;
  logic [WORD_W-1:0] status;

  assign tm = bus.to_memory_bus;
  assign tm_idx = tm[LINE_OFS +: IDX_W];
  // The read stream waits out the array latency, then feeds the buffer.
  assign push_valid = s.rd_pend && (s.wait_cnt == '0);
  // An I/O operation owns the outgoing bus for one cycle and stalls reads.
  assign pop_ready = !bus.io_operation;
  assign status = {{(WORD_W-MOD_COUNT_POS-3){1'b0}}, 3'(NUM_MODULES),
                   {(MOD_COUNT_POS-2){1'b0}}, s.err};

  two_entry_buffer #(.W(WORD_W), .DEPTH(2)) read_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(push_valid),
    .in_ready_o(push_ready),
    .in_data_i(s.rd_buf[s.pcnt]),
    .out_valid_o(pop_valid),
    .out_ready_i(pop_ready),
    .out_data_o(pop_data)
  );

  always_comb begin
    next_s = s;
    next_s.drdy = 1'b0;
    next_s.io_rd_req = 1'b0;
    next_s.io_wr = 1'b0;
    next_s.io_drive = 1'b0;
    err_set = 2'h0;
    err_clr = 2'h0;

    // Arbiter: latch while idle, then one grant at a time, lowest first.
    if (s.latched == '0) begin
      next_s.grant = '0;
      next_s.latched = bus.bus_request; // R22
    end else if (s.grant == '0) begin
      next_s.grant = s.latched & (~s.latched + MASTERS'(1)); // R5 R22
    end else if ((s.grant & bus.bus_request) == '0) begin
      next_s.latched = s.latched & ~s.grant; // R22
      next_s.grant = '0;
    end

    case (s.st)
      S_IDLE: begin
        if (bus.read_start) begin
          next_s.st = S_RADDR;
          next_s.mem_rdy = 1'b0; // R12
        end else if (bus.write_start) begin
          next_s.st = S_WADDR; // R2
          next_s.mem_rdy = 1'b0; // R12
        end
      end
      S_RADDR: begin
        // Snapshot the line so an overlapped write cannot leak into it.
        next_s.rd_buf = s.mem[tm_idx]; // R2
        next_s.rd_pend = 1'b1;
        next_s.wait_cnt = LAT_W'(READ_LAT);
        next_s.pcnt = 2'h0;
        next_s.st = bus.write_start ? S_WADDR : S_BUSY; // R2 R3
        err_set[ERR_RANGE] = tm[31:0] >= MEM_TOP; // R1
        err_set[ERR_PARITY] = !parity_ok(tm);
      end
      S_WADDR: begin
        next_s.wr_idx = tm_idx;
        next_s.wcnt = 2'h0;
        next_s.st = S_WDATA;
        err_set[ERR_RANGE] = tm[31:0] >= MEM_TOP; // R1
        err_set[ERR_PARITY] = !parity_ok(tm);
      end
      S_WDATA: begin
        next_s.mem[s.wr_idx][s.wcnt] = tm[31:0]; // R3
        next_s.wcnt = s.wcnt + 2'h1;
        err_set[ERR_PARITY] = !parity_ok(tm);
        if (s.wcnt == 2'h3) begin
          next_s.st = S_BUSY; // R1
        end
      end
      S_BUSY: begin
        if (!s.rd_pend && !pop_valid) begin
          next_s.st = S_IDLE;
          next_s.mem_rdy = MEM_READY_RST; // R12
        end
      end
      default: next_s.st = S_IDLE;
    endcase

    if (s.rd_pend && s.wait_cnt != '0) begin
      next_s.wait_cnt = s.wait_cnt - LAT_W'(1); // R3
    end
    if (push_valid && push_ready) begin
      next_s.pcnt = s.pcnt + 2'h1;
      if (s.pcnt == 2'h3) begin
        next_s.rd_pend = 1'b0; // R1
      end
    end

    if (s.io_drive) begin
      next_s.io_rdy = 1'b1; // R20
    end
    if (io_rd_valid_i) begin
      next_s.creg[IO_DATA_REG] = io_rd_data_i;
    end
    if (bus.io_operation) begin
      next_s.fmb = with_parity(s.sel == STATUS_REG ? status
                                                   : s.creg[s.sel]); // R16
      next_s.sel = bus.controller_register_number; // R19
      next_s.io_drive = 1'b1;
      next_s.io_rdy = 1'b0; // R20
      next_s.io_rd_req = bus.io_read_start; // R18
      next_s.io_wr = bus.io_write_start; // R18
      next_s.io_wr_data = tm[31:0];
      if (bus.load_controller_register) begin
        if (bus.controller_register_number == STATUS_REG) begin
          err_clr = tm[1:0]; // R18
        end else begin
          next_s.creg[bus.controller_register_number] = tm[31:0]; // R18
        end
      end
    end else if (pop_valid) begin
      next_s.fmb = with_parity(pop_data); // R23
      next_s.drdy = s.ocnt == 2'h0; // R13
      next_s.ocnt = s.ocnt + 2'h1;
    end

    // A new error in the clearing cycle is kept.
    next_s.err = (s.err & ~err_clr) | err_set;
    // The device line is asynchronous, so it passes two flip-flops first.
    next_s.irq_sync = {s.irq_sync[0], device_irq_i};
    next_s.irq = (next_s.err != 2'h0) || s.irq_sync[1]; // R7
  end

  // Outputs change only at the clock edge, the start of a bus cycle.
  always_ff @(posedge clk_i) begin // R21
    if (rst_i) begin
      s <= '0;
      s.mem_rdy <= MEM_READY_RST;
      s.io_rdy <= IO_READY_RST;
    end else begin
      s <= next_s;
    end
  end

  assign bus.bus_grant_a = s.grant;
  assign bus.mem_ready = s.mem_rdy;
  assign bus.read_data_ready = s.drdy;
  assign bus.io_ready = s.io_rdy;
  assign bus.from_memory_bus = s.fmb;
  assign bus.irq_oe_d = s.irq;
  assign io_rd_req_o = s.io_rd_req;
  assign io_wr_valid_o = s.io_wr;
  assign io_wr_data_o = s.io_wr_data;
endmodule
`default_nettype wire

// *** verif/global_bus_properties.sv ***
/* Checker of the global bus signals between the two ends.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module global_bus_properties import global_bus_pkg::*; (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic [MASTERS-1:0] bus_request, // Requests
  input wire logic [MASTERS-1:0] bus_grant_a, // Grants
  input wire logic read_start, // Read start
  input wire logic write_start, // Write start
  input wire logic mem_ready, // Memory idle
  input wire logic read_data_ready, // First word
  input wire logic io_operation, // I/O strobe
  input wire logic io_ready // I/O idle
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_grant_one_hot: assert property ($onehot0(bus_grant_a))
    else $error("grant not one-hot");
  a_grant_has_request: assert property (|bus_grant_a |->
    |(bus_grant_a & $past(bus_request))) else $error("grant unrequested");
  a_ready_drops: assert property (read_start && mem_ready |=>
    !mem_ready) else $error("mem_ready stayed up");
  a_busy_bounded: assert property ($fell(mem_ready) |->
    ##[1:60] mem_ready) else $error("memory stuck busy");
  a_write_after_read: assert property (write_start |->
    $past(read_start)) else $error("write_start alone");
  a_io_ready_cycle: assert property (io_operation |=>
    !io_ready ##1 io_ready) else $error("io_ready timing");
  a_first_word_busy: assert property (read_data_ready |->
    !mem_ready) else $error("data ready while idle");
  a_words_spaced: assert property (read_data_ready |=>
    !read_data_ready [*3]) else $error("data ready repeated");
  c_write: cover property (write_start);
  c_data: cover property (read_data_ready);
  c_io: cover property (io_operation);
endmodule
`default_nettype wire

// *** verif/global_bus_memory_io_protocol_tb.sv ***
/* Bench joining both bus ends, driven by cache end commands.
   Assumes default controller parameters; other_* stand for a second cache. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
  n_errors++; $display("BAD %s exp %h got %h", n, e, a); end end
module global_bus_memory_io_protocol_tb import global_bus_pkg::*;;
  int n_errors = 0;
  int samples_checked = 0;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cv = 1'b0;
  logic rdy, lv, iv, ext, sd;
  logic dirq = 1'b0, clr = 1'b0;
  logic [3:0] op = 4'h0;
  logic [31:0] ca = 32'h0, cw = 32'h0, io_data, wr_data;
  logic [127:0] cl = 128'h0, line;
  logic [2:0] cr = 3'h0;
  global_bus_if bus();
  memory_controller_end u_memory_controller_end (.clk_i(clk_i),
    .rst_i(rst_i), .bus(bus), .device_irq_i(dirq), .io_rd_valid_i(1'b0),
    .io_rd_data_i(32'h0), .io_rd_req_o(), .io_wr_valid_o(),
    .io_wr_data_o(wr_data));
  cache_controller_end u_cache_controller_end (.clk_i(clk_i),
    .rst_i(rst_i), .bus(bus), .cmd_valid_i(cv), .cmd_op_i(op),
    .cmd_addr_i(ca), .cmd_waddr_i(cw), .cmd_line_i(cl), .cmd_creg_i(cr),
    .ext_irq_clr_i(clr), .cmd_ready_o(rdy), .line_valid_o(lv),
    .line_o(line), .io_valid_o(iv), .io_data_o(io_data),
    .send_done_o(sd), .local_interrupt_o(), .ext_irq_o(ext));
  global_bus_properties u_global_bus_properties (.clk_i(clk_i),
    .rst_i(rst_i), .bus_request(bus.bus_request),
    .bus_grant_a(bus.bus_grant_a), .read_start(bus.read_start),
    .write_start(bus.write_start), .mem_ready(bus.mem_ready),
    .read_data_ready(bus.read_data_ready),
    .io_operation(bus.io_operation), .io_ready(bus.io_ready));
  initial forever #25 clk_i = ~clk_i;
  task cmd(input logic [3:0] o, input logic [31:0] a, w,
           input logic [127:0] l, input logic [2:0] r);
    @(posedge clk_i) #1;
    {op, ca, cw, cl, cr} = {o, a, w, l, r};
    cv = 1'b1;
    while (rdy !== 1'b1) @(posedge clk_i) #1;
    @(posedge clk_i) #1;
    cv = 1'b0;
  endtask
  task get;
    for (int i = 0; i < 200 && lv !== 1'b1 && iv !== 1'b1; i++)
      @(posedge clk_i) #1;
    `CHK("done", 1'b1, lv | iv)
  endtask
  task finish_test;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    #500000;
    n_errors++;
    finish_test;
  end
  initial begin
    {bus.other_request, bus.other_data, bus.other_oe} = '0;
    {bus.other_send, bus.other_receive_oe, bus.other_match_oe} = '0;
    bus.other_irq_oe = '0;
    repeat (8) @(posedge clk_i);
    #1 rst_i = 1'b0;
    cmd(OP_WRITE, 32'h20, 32'h20, 128'h44_33_22_11, 3'h0);
    cmd(OP_READ_WRITE, 32'h20, 32'h40, 128'h88_77_66_55, 3'h0);
    get;
    `CHK("rw line", 128'h44_33_22_11, line)
    cmd(OP_READ, 32'h40, 32'h40, 128'h0, 3'h0);
    get;
    `CHK("rd line", 128'h88_77_66_55, line)
    $display("memory test done");
    cmd(OP_LOAD_REG, 32'h0, 32'h0, 128'h5a5a, 3'h3);
    get;
    cmd(OP_IO_PEEK, 32'h0, 32'h0, 128'h0, 3'h0);
    get;
    `CHK("reg3", 32'h5a5a, io_data)
    cmd(OP_IO_PEEK, 32'h0, 32'h0, 128'h0, 3'h0);
    get;
    `CHK("status", 32'(MAX_MODULES) << MOD_COUNT_POS, io_data)
    cmd(OP_IO_WRITE, 32'h0, 32'h0, 128'h77aa, 3'h0);
    get;
    `CHK("io wr", 32'h77aa, wr_data)
    `CHK("irq", 1'b0, ext)
    dirq = 1'b1;
    repeat (6) @(posedge clk_i) #1;
    `CHK("irq set", 1'b1, ext)
    {dirq, clr} = 2'b01;
    repeat (6) @(posedge clk_i) #1;
    `CHK("irq clr", 1'b0, ext)
    $display("io test done");
    cmd(OP_RECEIVE, 32'h80, 32'h0, 128'h0, 3'h0);
    {bus.other_oe, bus.other_send} = 2'b11;
    for (int i = 0; i < 5; i++) begin
      bus.other_data = with_parity(i == 0 ? 32'h80 : 32'(i));
      if (i == 2) `CHK("match", 1'b0, bus.remote_match_n)
      @(posedge clk_i) #1;
    end
    {bus.other_oe, bus.other_send} = 2'b00;
    get;
    `CHK("rx line", 128'h00000004_00000003_00000002_00000001, line)
    cmd(OP_SEND, 32'h80, 32'h0, 128'h0, 3'h0);
    repeat (30) @(posedge clk_i) #1;
    `CHK("stalled", 1'b0, rdy)
    {bus.other_receive_oe, bus.other_match_oe} = 2'b11;
    for (int i = 0; i < 100 && sd !== 1'b1; i++) @(posedge clk_i) #1;
    `CHK("sent", 1'b1, sd)
    $display("link test done");
    finish_test;
  end
endmodule
`default_nettype wire
